// ---- logic/flash_spi_device.sv ----
// Device end of the serial flash link: shifts bytes in and out on the
// link clock and hands them to user logic on the reference clock.
// Assumes the link clock period is longer than three reference periods,
// so a byte-done level is always seen by the three-stage synchroniser.
// In mode 3 select must stay low three reference periods before the
// first clock fall, so that the byte to send has settled.
`default_nettype none

// Operation
// - Select low selects; high deselects, output floats.
// - While deselected, serial input bits are ignored.
// - Select falling edge starts every new operation.
// - Select rising edge ends the current operation.
// - Standby waits for internal timed cycle end.
// - Input bits sampled on clock rising edge.
// - Output bits launched on clock falling edge.
// - Clock modes 0 and 3 only.
// - Host keeps clock at or below 70 MHz.
module flash_spi_device (
  flash_spi_if.dev          link,
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_busy,
  input  wire logic         i_tx_we,
  input  wire logic [7:0]   i_tx_data,
  output logic              o_rx_valid,
  output logic [7:0]        o_rx_data,
  output logic              o_rx_opcode,
  output logic              o_selected,
  output logic              o_standby,
  output logic              o_frame_end
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // One edge test serves the select and the byte-done paths, so the
  // two cannot drift apart.
  function automatic logic rise_of(input logic now_v, input logic old_v);
    return now_v & ~old_v;
  endfunction : rise_of

  // ***************************************************************
  // Link clock domain, receive side
  // ***************************************************************
  // Select high acts as the asynchronous clear of all link logic, so
  // every frame starts from bit zero and the bits clocked in while
  // deselected never reach a byte.
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  logic [7:0] rx_byte_q;
  logic       rx_rdy_q;
  logic       first_q;
  logic       rx_op_q;
  wire        byte_done = (bit_cnt_q == flash_spi_pkg::BIT_LAST);

  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_q <= flash_spi_pkg::BIT_FIRST;
      rx_sh_q   <= '0;
      rx_byte_q <= '0;
      rx_rdy_q  <= 1'b0;
      first_q   <= 1'b1;
      rx_op_q   <= 1'b0;
    end else begin
      rx_sh_q   <= {rx_sh_q[5:0], link.mosi};
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_rdy_q  <= byte_done;
      if (byte_done) begin
        rx_byte_q <= {rx_sh_q, link.mosi};
        rx_op_q   <= first_q;
        first_q   <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Link clock domain, transmit side
  // ***************************************************************
  // The byte to send is taken at the falling edge that follows a full
  // byte, which in mode 3 includes the idle-high edge before the first
  // bit. The enable rises on the first falling edge, which in mode 0
  // comes after the host has sampled the first output bit.
  logic [7:0] tx_q;
  logic [7:0] tx_sh_q;
  logic       miso_q;
  logic       oe_q;
  wire        tx_load = (bit_cnt_q == flash_spi_pkg::BIT_FIRST);

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      tx_sh_q <= flash_spi_pkg::TX_RESET;
      miso_q  <= flash_spi_pkg::LINE_IDLE;
      oe_q    <= 1'b0;
    end else begin
      oe_q <= 1'b1;
      if (tx_load) begin
        miso_q  <= tx_q[7];
        tx_sh_q <= {tx_q[6:0], 1'b0};
      end else begin
        miso_q  <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  assign link.miso_o  = miso_q;
  assign link.miso_oe = oe_q;

  // ***************************************************************
  // Reference clock domain
  // ***************************************************************
  // Select and byte-done cross as levels through three flops each. The
  // received byte itself is held for seven more link clocks, so it is
  // stable whenever the synchronised edge allows it to be read.
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic rdy_s1_q, rdy_s2_q, rdy_s3_q;
  logic rx_valid_q, rx_op_out_q, sel_q, stby_q, fend_q;
  logic [7:0] rx_data_q;

  wire rdy_rise = rise_of(rdy_s2_q, rdy_s3_q);
  wire cs_rise  = rise_of(cs_s2_q, cs_s3_q);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      rdy_s3_q <= 1'b0;
    end else begin
      rdy_s1_q <= rx_rdy_q;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rx_valid_q  <= 1'b0;
      rx_data_q   <= '0;
      rx_op_out_q <= 1'b0;
    end else begin
      rx_valid_q <= rdy_rise;
      if (rdy_rise) begin
        rx_data_q   <= rx_byte_q;
        rx_op_out_q <= rx_op_q;
      end
    end
  end

  // The next byte to send is staged here and copied into the register
  // that the link reads only while select is seen high on both late
  // synchroniser stages. The link reads that register only while
  // selected, so it never sees a word half written. The cost: a byte
  // written during a frame is sent from the next frame on.
  logic [7:0] tx_next_q;
  wire        tx_open = cs_s2_q & cs_s3_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tx_next_q <= flash_spi_pkg::TX_RESET;
    end else if (i_tx_we) begin
      tx_next_q <= i_tx_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tx_q <= flash_spi_pkg::TX_RESET;
    end else if (tx_open) begin
      tx_q <= tx_next_q;
    end
  end

  // Standby is a status level only. A timed internal cycle keeps it
  // low after select rises, until the busy input drops.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      sel_q  <= 1'b0;
      stby_q <= 1'b1;
      fend_q <= 1'b0;
    end else begin
      sel_q  <= ~cs_s2_q;
      stby_q <= cs_s2_q & ~i_busy;
      fend_q <= cs_rise;
    end
  end

  assign o_rx_valid  = rx_valid_q;
  assign o_rx_data   = rx_data_q;
  assign o_rx_opcode = rx_op_out_q;
  assign o_selected  = sel_q;
  assign o_standby   = stby_q;
  assign o_frame_end = fend_q;

endmodule : flash_spi_device

`default_nettype wire

// ---- logic/flash_spi_host.sv ----
// Host end of the serial flash link: a byte FIFO feeds a sequencer that
// frames each operation with select and makes the serial clock.
// Assumes user logic marks the last byte of each operation.
`default_nettype none

// ***************************************************************
// Byte FIFO with registered flags
// ***************************************************************
module flash_byte_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q, cnt_d;
  logic          in_rdy_q, out_vld_q;

  wire push = i_in_valid & in_rdy_q;
  wire pop  = out_vld_q & i_out_ready;

  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_rdy_q  <= 1'b0;
      out_vld_q <= 1'b0;
    end else begin
      wr_q      <= wr_q + AW'(push);
      rd_q      <= rd_q + AW'(pop);
      cnt_q     <= cnt_d;
      in_rdy_q  <= cnt_d != (AW+1)'(DEPTH);
      out_vld_q <= cnt_d != '0;
    end
  end

  assign o_in_ready  = in_rdy_q;
  assign o_out_valid = out_vld_q;
  assign o_out_data  = mem[rd_q];

endmodule : flash_byte_fifo

// ***************************************************************
// Host sequencer
// ***************************************************************
module flash_spi_host #(
  parameter int SCK_HALF = flash_spi_pkg::SCK_HALF_DEF,
  parameter int DEPTH    = flash_spi_pkg::FIFO_DEPTH
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  flash_spi_if.host         link,
  input  wire logic         i_tx_valid,
  input  wire logic [7:0]   i_tx_data,
  input  wire logic         i_tx_last,
  output logic              o_tx_ready,
  output logic              o_rx_valid,
  output logic [7:0]        o_rx_data
);

  // Never below the fewest cycles that respect the top clock rate.
  localparam int HALF = (SCK_HALF > flash_spi_pkg::SCK_MIN_HALF) ?
                        SCK_HALF : flash_spi_pkg::SCK_MIN_HALF;
  localparam int DW   = $clog2(HALF + 1);

  logic       f_valid;
  logic [8:0] f_data;
  wire        f_ready;

  flash_byte_fifo #(
    .W     (flash_spi_pkg::FIFO_W),
    .DEPTH (DEPTH)
  ) flash_byte_fifo_inst (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_tx_valid),
    .i_in_data   ({i_tx_last, i_tx_data}),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_ready)
  );

  flash_spi_pkg::host_state_t st_q;
  logic [DW-1:0] div_q;
  logic [2:0]    bit_q;
  logic [7:0]    tx_sh_q, rx_sh_q, rx_q;
  logic          cs_n_q, sck_q, mosi_q, last_q, rx_vld_q;
  logic          miso_s1_q, miso_s2_q;

  wire tick = (div_q == DW'(HALF - 1));
  assign f_ready = (st_q == flash_spi_pkg::HS_LOAD);

  // The data line from the device is a pin input and is synchronised.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      miso_s1_q <= flash_spi_pkg::LINE_IDLE;
      miso_s2_q <= flash_spi_pkg::LINE_IDLE;
    end else begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      div_q <= '0;
    end else if (tick || st_q == flash_spi_pkg::HS_LOAD ||
                 st_q == flash_spi_pkg::HS_IDLE) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  // An empty FIFO in mid operation parks the clock low with select
  // held, so the frame stalls instead of breaking.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_q     <= flash_spi_pkg::HS_IDLE;
      cs_n_q   <= 1'b1;
      sck_q    <= 1'b0;
      mosi_q   <= 1'b0;
      bit_q    <= '0;
      tx_sh_q  <= '0;
      rx_sh_q  <= '0;
      rx_q     <= '0;
      last_q   <= 1'b0;
      rx_vld_q <= 1'b0;
    end else begin
      rx_vld_q <= 1'b0;
      case (st_q)
        flash_spi_pkg::HS_IDLE: begin
          if (f_valid) begin
            cs_n_q <= 1'b0;
            st_q   <= flash_spi_pkg::HS_LOAD;
          end
        end
        flash_spi_pkg::HS_LOAD: begin
          if (f_valid) begin
            tx_sh_q <= f_data[7:0];
            mosi_q  <= f_data[7];
            last_q  <= f_data[8];
            bit_q   <= flash_spi_pkg::BIT_FIRST;
            st_q    <= flash_spi_pkg::HS_SHIFT;
          end
        end
        flash_spi_pkg::HS_SHIFT: begin
          if (tick && !sck_q) begin
            sck_q   <= 1'b1;
            rx_sh_q <= {rx_sh_q[6:0], miso_s2_q};
          end else if (tick) begin
            sck_q <= 1'b0;
            if (bit_q == flash_spi_pkg::BIT_LAST) begin
              rx_q     <= rx_sh_q;
              rx_vld_q <= 1'b1;
              st_q     <= last_q ? flash_spi_pkg::HS_GAP
                                 : flash_spi_pkg::HS_LOAD;
              cs_n_q   <= last_q;
            end else begin
              bit_q   <= bit_q + 3'h1;
              mosi_q  <= tx_sh_q[6];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
          end
        end
        flash_spi_pkg::HS_GAP: begin
          if (tick) begin
            st_q <= flash_spi_pkg::HS_IDLE;
          end
        end
        default: begin
          st_q <= flash_spi_pkg::HS_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n  = cs_n_q;
  assign link.sck   = sck_q;
  assign link.mosi  = mosi_q;
  assign o_rx_valid = rx_vld_q;
  assign o_rx_data  = rx_q;

endmodule : flash_spi_host

`default_nettype wire

// ---- logic/flash_spi_if.sv ----
// Four-wire serial link between the flash front end and its host.
// Assumes the host drives select, clock and data in; the device drives
// data out only while its enable is high, otherwise the line floats high.
`default_nettype none

interface flash_spi_if;

  logic cs_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Released line is pulled high.
  assign miso = miso_oe ? miso_o : flash_spi_pkg::LINE_IDLE;

  modport dev (
    input  cs_n,
    input  sck,
    input  mosi,
    output miso_o,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sck,
    output mosi,
    input  miso
  );

endinterface : flash_spi_if

`default_nettype wire

// ---- logic/flash_spi_pkg.sv ----
// Shared constants for the serial flash front end and its host controller.
// Assumes both ends and the bench compile this package first.
`default_nettype none

package flash_spi_pkg;

  // ***************************************************************
  // Widths and counts
  // ***************************************************************
  localparam int          BYTE_W       = 8;
  localparam int          BIT_CNT_W    = 3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  BIT_FIRST    = 3'h0;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          FIFO_W       = BYTE_W + 1;

  // ***************************************************************
  // Reset values and idle levels
  // ***************************************************************
  localparam logic [7:0]  TX_RESET     = 8'hFF;
  localparam logic        LINE_IDLE    = 1'h1;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int          REF_CLK_KHZ  = 40000;
  localparam int          SCK_MAX_KHZ  = 70000;
  // Fewest reference cycles per half period that keep the serial
  // clock at or below its highest rate.
  localparam int          SCK_MIN_HALF =
    (REF_CLK_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
  localparam int          SCK_HALF_DEF = 3;

  // ***************************************************************
  // Host sequencer states, Gray coded along the usual path
  // ***************************************************************
  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_LOAD  = 2'h1,
    HS_SHIFT = 2'h3,
    HS_GAP   = 2'h2
  } host_state_t;

endpackage : flash_spi_pkg

`default_nettype wire

// ---- tb/flash_link_monitor.sv ----
// Concurrent checks on the serial link between host and flash front end.
// Assumes the bench instantiates it beside the link interface.
`default_nettype none

module flash_link_monitor (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************
  // Clock rises counted within each frame
  // ****************************************************
  // Twelve bits so that long frames do not wrap to a whole byte count.
  logic        sck_q;
  logic [11:0] rise_q;
  logic [11:0] rise_d;
  logic        rise_w;

  assign rise_w = sck & ~sck_q;
  assign rise_d = cs_n ? 12'h000 : rise_q + {11'h000, rise_w};

  always_ff @(posedge i_ref_clk) begin
    sck_q  <= sck;
    rise_q <= rise_d;
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  AST_RELEASED_HIGH: assert property (
    cs_n && $past(cs_n) |-> !miso_oe && miso)
    else $error("Data out driven while deselected.");
  AST_START_ON_SELECT: assert property (
    $fell(cs_n) |-> !sck ##[1:20] $rose(sck))
    else $error("Frame start without clock after select.");
  AST_END_ON_BYTE: assert property (
    $rose(cs_n) |-> rise_q[2:0] == 3'h0 && rise_q != 12'h000)
    else $error("Frame ended off a byte boundary.");
  AST_SAMPLE_STABLE: assert property (
    $rose(sck) && !cs_n |-> $stable(mosi))
    else $error("Data in moved at the sampling edge.");
  AST_LAUNCH_ON_FALL: assert property (
    !cs_n && !$past(cs_n) && miso_oe && $changed(miso_o) |-> $fell(sck))
    else $error("Data out changed off a falling clock edge.");
  AST_ENABLE_ON_FALL: assert property (
    $rose(miso_oe) |-> $fell(sck) && !cs_n)
    else $error("Data out enabled off a falling clock edge.");
  AST_IDLE_LOW: assert property (
    cs_n |-> !sck)
    else $error("Clock not idle low outside a frame.");
  AST_HALF_PERIOD: assert property (
    $rose(sck) |=> sck [*2])
    else $error("Clock high phase too short.");

  cover property ($rose(cs_n) && rise_q > 12'h008);
  cover property ($rose(miso_oe));
  cover property ($fell(cs_n));

endmodule : flash_link_monitor

`default_nettype wire

// ---- tb/serial_flash_spi_frontend_tb_top.sv ----
// Bench joining host and flash front end over the serial link.
// Assumes the package, interface and both ends are compiled first.
`default_nettype none

module serial_flash_spi_frontend_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_ref_clk = 1'b0;
  logic       i_nrst    = 1'b0;
  logic       busy      = 1'b0;
  logic       tx_we     = 1'b0;
  logic [7:0] tx_byte   = 8'hFF;
  logic       h_valid   = 1'b0;
  logic       h_last    = 1'b0;
  logic [7:0] h_data    = 8'h00;
  logic       h_ready, h_rvalid, d_rvalid, d_op, d_sel, d_stby, d_end;
  logic [7:0] h_rdata, d_rdata;
  logic [8:0] e;
  logic       full_seen = 1'b0;
  logic       sel_seen  = 1'b0;
  int         err_count = 0;
  int         n_checks  = 0;
  int         ends      = 0;
  int         nf        = 0;
  logic [8:0] dq[$];
  logic [8:0] hq[$];

  always #12.5 i_ref_clk = ~i_ref_clk;

  flash_spi_if link ();

  flash_spi_host flash_spi_host_inst (.i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst), .link(link.host), .i_tx_valid(h_valid),
    .i_tx_data(h_data), .i_tx_last(h_last), .o_tx_ready(h_ready),
    .o_rx_valid(h_rvalid), .o_rx_data(h_rdata));

  flash_spi_device flash_spi_device_inst (.link(link.dev),
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_busy(busy),
    .i_tx_we(tx_we), .i_tx_data(tx_byte), .o_rx_valid(d_rvalid),
    .o_rx_data(d_rdata), .o_rx_opcode(d_op), .o_selected(d_sel),
    .o_standby(d_stby), .o_frame_end(d_end));

  flash_link_monitor flash_link_monitor_inst (.i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst), .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // The first byte read back in a frame is the released line level and
  // then the reset send byte: the device loads its byte after a full one.
  task automatic push(input logic [7:0] b, input logic first, last);
    @(negedge i_ref_clk);
    h_valid = 1'b1;
    h_data  = b;
    h_last  = last;
    do begin
      @(posedge i_ref_clk);
      if (h_ready === 1'b0) full_seen = 1'b1;
    end while (h_ready !== 1'b1);
    dq.push_back({first, b});
    hq.push_back({1'b1, first ? {flash_spi_pkg::LINE_IDLE,
      flash_spi_pkg::TX_RESET[7:1]} : tx_byte});
  endtask : push

  task automatic frame(input int n);
    int k;
    for (int i = 0; i < n; i++) push(8'($urandom), i == 0, i == n - 1);
    @(negedge i_ref_clk);
    h_valid = 1'b0;
    nf++;
    k = 0;
    while ((dq.size() != 0 || hq.size() != 0) && k < 4000) begin
      @(posedge i_ref_clk);
      k++;
    end
    chk(9'(dq.size() + hq.size()), 9'h000);
    repeat (8) @(posedge i_ref_clk);
  endtask : frame

  task automatic set_tx(input logic [7:0] b);
    @(negedge i_ref_clk);
    tx_byte = b;
    tx_we   = 1'b1;
    @(negedge i_ref_clk);
    tx_we   = 1'b0;
  endtask : set_tx

  // ****************************************************
  // Result watcher
  // ****************************************************
  always @(posedge i_ref_clk) begin
    if (d_end === 1'b1) ends++;
    if (d_sel === 1'b1) sel_seen = 1'b1;
    if (d_rvalid === 1'b1) begin
      e = dq.size() != 0 ? dq.pop_front() : 9'hXXX;
      chk({d_op, d_rdata}, e);
    end
    if (h_rvalid === 1'b1) begin
      e = hq.size() != 0 ? hq.pop_front() : 9'hXXX;
      chk({1'b1, h_rdata}, e);
    end
  end

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    void'($urandom(32'h037B95AB));
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_nrst = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    chk({8'h00, d_stby}, 9'h001);
    chk({8'h00, d_sel}, 9'h000);
    frame(20);
    chk({8'h00, full_seen}, 9'h001);
    chk({8'h00, sel_seen}, 9'h001);
    $display("test long frame done");
    for (int f = 0; f < 4; f++) begin
      set_tx(8'($urandom));
      frame(1 + int'($urandom % 4));
    end
    chk(9'(ends), 9'(nf));
    $display("test short frames done");
    @(negedge i_ref_clk);
    busy = 1'b1;
    frame(2);
    chk({8'h00, d_stby}, 9'h000);
    @(negedge i_ref_clk);
    busy = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk({8'h00, d_stby}, 9'h001);
    chk(9'(ends), 9'(nf));
    $display("test standby done");
    summarize();
  end

  // Generous bound: the whole run needs a few thousand cycles.
  initial begin
    #(25 * 60000);
    err_count++;
    summarize();
  end

endmodule : serial_flash_spi_frontend_tb_top

`default_nettype wire
